// ---- logic/desc_attr_pkg.sv ----
// constants for the descriptor attribute register bank
// assumes a 32-bit AXI4-Lite slave port with 8-bit byte addresses
package desc_attr_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_OBJECT_STORE = 8'h50;
    localparam logic [7:0] OFS_SUPERSPEED = 8'h54;
    localparam logic [7:0] OFS_HIGHSPEED = 8'h58;
    localparam logic [7:0] OFS_EMUL_CTRL = 8'h7C;

    // ------------------------------------------------------------
    // field slots and layout
    // ------------------------------------------------------------
    localparam int NUM_FIELDS = 7;
    localparam int FLD_BOS_LEN = 0;
    localparam int FLD_SS_CFG = 1;
    localparam int FLD_SS_DEV = 2;
    localparam int FLD_SS_POLL = 3;
    localparam int FLD_HS_CFG = 4;
    localparam int FLD_HS_DEV = 5;
    localparam int FLD_HS_POLL = 6;
    localparam int CTRL_EMUL_BIT = 0;
    localparam int CTRL_EEPROM_BIT = 1;
    localparam int CTRL_OTP_BIT = 2;
    localparam int CTRL_ACTIVE_BIT = 3;

    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [7:0] LEN_FULL = 8'h12;
    localparam logic [7:0] SS_POLL_FALLBACK = 8'h06;
    localparam logic [7:0] HS_POLL_FALLBACK = 8'h04;
    localparam logic [7:0] LEN_FALLBACK = 8'h00;
    localparam logic [NUM_FIELDS-1:0][7:0] FIELD_FALLBACK = {
        HS_POLL_FALLBACK, LEN_FALLBACK, LEN_FALLBACK,
        SS_POLL_FALLBACK, LEN_FALLBACK, LEN_FALLBACK, LEN_FALLBACK};
    localparam logic EMUL_RESET = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : desc_attr_pkg

// ---- logic/image_select.sv ----
// picks the restore image for every attribute field
// assumes the eeprom and otp images are stable, same-clock levels
`timescale 1ns/1ps
module image_select
    import desc_attr_pkg::*;
(
    // sources present
    input wire logic eeprom_present,
    input wire logic otp_configured,
    // images
    input wire logic [desc_attr_pkg::NUM_FIELDS-1:0][7:0] eeprom_image,
    input wire logic [desc_attr_pkg::NUM_FIELDS-1:0][7:0] otp_image,
    output logic [desc_attr_pkg::NUM_FIELDS-1:0][7:0] image
);
    import desc_attr_pkg::*;

    genvar i;
    generate
        for (i = 0; i < NUM_FIELDS; i++) begin : g_field
            // eeprom first, then otp, then fixed fallback
            assign image[i] = eeprom_present ? eeprom_image[i] :
                              otp_configured ? otp_image[i] : FIELD_FALLBACK[i];
        end
    endgenerate

endmodule : image_select

// ---- logic/length_clamp.sv ----
// maps a descriptor length field to zero or the full length
// assumes purely combinational use inside one clock domain
`timescale 1ns/1ps
module length_clamp
    import desc_attr_pkg::*;
(
    // length
    input wire logic [7:0] len_in,
    output logic [7:0] len_out
);
    import desc_attr_pkg::*;

    assign len_out = (len_in == 8'h00) ? 8'h00 : LEN_FULL;

endmodule : length_clamp

// ---- logic/usb_descriptor_attribute_regs.sv ----
// descriptor attribute register bank behind an AXI4-Lite slave
// assumes one clock mclk, synchronous active-low rst_b, and
// eeprom/otp images held by the loader in the same clock domain
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps

module usb_descriptor_attribute_regs
    import desc_attr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [desc_attr_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [desc_attr_pkg::DATA_W-1:0] wdata,
    input wire logic [desc_attr_pkg::STRB_W-1:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [desc_attr_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [desc_attr_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // configuration sources
    input wire logic eeprom_present,
    input wire logic otp_configured,
    input wire logic [desc_attr_pkg::NUM_FIELDS-1:0][7:0] eeprom_image,
    input wire logic [desc_attr_pkg::NUM_FIELDS-1:0][7:0] otp_image,
    // restore events
    input wire logic usb_bus_reset,
    input wire logic lite_reset,
    // attributes for descriptor processing
    output logic attrs_active,
    output logic [7:0] object_store_block_len,
    output logic [7:0] superspeed_poll_interval,
    output logic [7:0] superspeed_device_len,
    output logic [7:0] superspeed_config_len,
    output logic [7:0] highspeed_poll_interval,
    output logic [7:0] highspeed_device_len,
    output logic [7:0] highspeed_config_len
);
    import desc_attr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_FIELDS-1:0][7:0] fields;
        logic [NUM_FIELDS-1:0][7:0] outs;
        logic active;
        logic emul_en;
        logic reload;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [DATA_W-1:0] w_data;
        logic [STRB_W-1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } state_type;

    localparam state_type STATE_RESET = '{
        fields: FIELD_FALLBACK,
        outs: '0,
        active: 1'b0,
        emul_en: EMUL_RESET,
        reload: 1'b1,
        aw_have: 1'b0,
        aw_addr: '0,
        w_have: 1'b0,
        w_data: '0,
        w_strb: '0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        rvalid: 1'b0,
        rdata: '0,
        rresp: RESP_OKAY
    };

    state_type st_r;
    state_type st_nxt;
    logic [NUM_FIELDS-1:0][7:0] image;
    logic [7:0] ss_dev_clamped;
    logic [7:0] ss_cfg_clamped;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    image_select u_image (
        .eeprom_present(eeprom_present),
        .otp_configured(otp_configured),
        .eeprom_image(eeprom_image),
        .otp_image(otp_image),
        .image(image)
    );

    length_clamp u_ss_dev_clamp (
        .len_in(st_r.fields[FLD_SS_DEV]),
        .len_out(ss_dev_clamped)
    );

    length_clamp u_ss_cfg_clamp (
        .len_in(st_r.fields[FLD_SS_CFG]),
        .len_out(ss_cfg_clamped)
    );

    // ------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------
    assign awready = !st_r.aw_have && !st_r.bvalid;
    assign wready = !st_r.w_have && !st_r.bvalid;
    assign arready = !st_r.rvalid;
    assign aw_hs = awvalid && awready;
    assign w_hs = wvalid && wready;
    assign ar_hs = arvalid && arready;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (aw_hs) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = awaddr;
        end
        if (w_hs) begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = wdata;
            st_nxt.w_strb = wstrb;
        end
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end
        // write commits once address and data are both held
        if (st_nxt.aw_have && st_nxt.w_have) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            // reserved lanes and bits are simply dropped
            case ({st_nxt.aw_addr[ADDR_W-1:2], 2'b00})
                OFS_OBJECT_STORE: begin
                    if (st_nxt.w_strb[0]) st_nxt.fields[FLD_BOS_LEN] = st_nxt.w_data[7:0];
                end
                OFS_SUPERSPEED: begin
                    if (st_nxt.w_strb[0]) st_nxt.fields[FLD_SS_CFG] = st_nxt.w_data[7:0];
                    if (st_nxt.w_strb[1]) st_nxt.fields[FLD_SS_DEV] = st_nxt.w_data[15:8];
                    if (st_nxt.w_strb[2]) st_nxt.fields[FLD_SS_POLL] = st_nxt.w_data[23:16];
                end
                OFS_HIGHSPEED: begin
                    if (st_nxt.w_strb[0]) st_nxt.fields[FLD_HS_CFG] = st_nxt.w_data[7:0];
                    if (st_nxt.w_strb[1]) st_nxt.fields[FLD_HS_DEV] = st_nxt.w_data[15:8];
                    if (st_nxt.w_strb[2]) st_nxt.fields[FLD_HS_POLL] = st_nxt.w_data[23:16];
                end
                OFS_EMUL_CTRL: begin
                    if (st_nxt.w_strb[0]) st_nxt.emul_en = st_nxt.w_data[CTRL_EMUL_BIT];
                end
                default: begin
                    st_nxt.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (ar_hs) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            st_nxt.rdata = '0;
            case ({araddr[ADDR_W-1:2], 2'b00})
                OFS_OBJECT_STORE: begin
                    st_nxt.rdata = {24'h000000, st_r.fields[FLD_BOS_LEN]};
                end
                OFS_SUPERSPEED: begin
                    st_nxt.rdata = {8'h00, st_r.fields[FLD_SS_POLL], st_r.fields[FLD_SS_DEV],
                                    st_r.fields[FLD_SS_CFG]};
                end
                OFS_HIGHSPEED: begin
                    st_nxt.rdata = {8'h00, st_r.fields[FLD_HS_POLL], st_r.fields[FLD_HS_DEV],
                                    st_r.fields[FLD_HS_CFG]};
                end
                OFS_EMUL_CTRL: begin
                    st_nxt.rdata[CTRL_EMUL_BIT] = st_r.emul_en;
                    st_nxt.rdata[CTRL_EEPROM_BIT] = eeprom_present;
                    st_nxt.rdata[CTRL_OTP_BIT] = otp_configured;
                    st_nxt.rdata[CTRL_ACTIVE_BIT] = st_r.active;
                end
                default: begin
                    st_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        // restore beats a software write in the same cycle
        st_nxt.reload = 1'b0;
        if (st_r.reload || usb_bus_reset || lite_reset) begin
            st_nxt.fields = image;
        end
        st_nxt.active = !eeprom_present && !otp_configured && st_r.emul_en;
        st_nxt.outs = '0;
        if (st_r.active) begin
            st_nxt.outs = st_r.fields;
            st_nxt.outs[FLD_SS_DEV] = ss_dev_clamped;
            st_nxt.outs[FLD_SS_CFG] = ss_cfg_clamped;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r <= STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign attrs_active = st_r.active;
    assign object_store_block_len = st_r.outs[FLD_BOS_LEN];
    assign superspeed_poll_interval = st_r.outs[FLD_SS_POLL];
    assign superspeed_device_len = st_r.outs[FLD_SS_DEV];
    assign superspeed_config_len = st_r.outs[FLD_SS_CFG];
    assign highspeed_poll_interval = st_r.outs[FLD_HS_POLL];
    assign highspeed_device_len = st_r.outs[FLD_HS_DEV];
    assign highspeed_config_len = st_r.outs[FLD_HS_CFG];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    a_bos_read_layout: assert property (
        (ar_hs && {araddr[ADDR_W-1:2], 2'b00} == OFS_OBJECT_STORE) |=>
            (rdata[31:8] == 24'h000000 && rdata[7:0] == $past(st_r.fields[FLD_BOS_LEN])))
        else $error("object store read layout wrong");

    a_inactive_zero: assert property (
        (eeprom_present || otp_configured || !st_r.emul_en) |=>
            !attrs_active ##1 (object_store_block_len == 8'h00 && highspeed_poll_interval == 8'h00))
        else $error("attributes leak while inactive");

    a_release_loads: assert property (
        ($past(rst_b) == 1'b0) |=> (st_r.fields[FLD_BOS_LEN] == $past(image[FLD_BOS_LEN])))
        else $error("reset did not load object store length");

    a_restore_image: assert property (
        (usb_bus_reset || lite_reset) |=> (st_r.fields == $past(image)))
        else $error("bus or lite reset did not restore image");

    a_ss_layout: assert property (
        (ar_hs && {araddr[ADDR_W-1:2], 2'b00} == OFS_SUPERSPEED) |=>
            (rdata == {8'h00, $past(st_r.fields[FLD_SS_POLL]), $past(st_r.fields[FLD_SS_DEV]),
                       $past(st_r.fields[FLD_SS_CFG])}))
        else $error("superspeed read layout wrong");

    a_ss_poll_six: assert property (
        (lite_reset && !eeprom_present && !otp_configured) |=> (st_r.fields[FLD_SS_POLL] == 8'h06))
        else $error("superspeed poll fallback not six");

    a_ss_len_full: assert property (
        (st_r.active && st_r.fields[FLD_SS_DEV] != 8'h00) |=> (superspeed_device_len == 8'h12))
        else $error("superspeed length not normalised");

    a_ss_len_zero: assert property (
        (usb_bus_reset && !eeprom_present && !otp_configured) |=>
            (st_r.fields[FLD_SS_DEV] == 8'h00 && st_r.fields[FLD_SS_CFG] == 8'h00))
        else $error("superspeed length fallback not zero");

    a_hs_write_lanes: assert property (
        ((aw_hs || st_r.aw_have) && (w_hs || st_r.w_have) && !st_r.reload
         && !usb_bus_reset && !lite_reset && {st_nxt.aw_addr[ADDR_W-1:2], 2'b00} == OFS_HIGHSPEED
         && st_nxt.w_strb[2]) |=> (st_r.fields[FLD_HS_POLL] == $past(st_nxt.w_data[23:16])))
        else $error("highspeed poll write lost");

    a_hs_poll_four: assert property (
        (usb_bus_reset && !eeprom_present && !otp_configured) |=> (st_r.fields[FLD_HS_POLL] == 8'h04))
        else $error("highspeed poll fallback not four");

    a_hs_len_zero: assert property (
        (lite_reset && !eeprom_present && !otp_configured) |=>
            (st_r.fields[FLD_HS_DEV] == 8'h00 && st_r.fields[FLD_HS_CFG] == 8'h00))
        else $error("highspeed length fallback not zero");

endmodule : usb_descriptor_attribute_regs

// ---- testbench/tb.sv ----
// self-checking bench for the descriptor attribute register bank
// assumes the bank at 0x50..0x58, control word at 0x7C, one 40 MHz clock
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb;
    import desc_attr_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic awvalid = 1'b0;
    logic awready;
    logic [ADDR_W-1:0] awaddr = 8'h00;
    logic wvalid = 1'b0;
    logic wready;
    logic [DATA_W-1:0] wdata = 32'h00000000;
    logic [STRB_W-1:0] wstrb = 4'h0;
    logic bvalid;
    logic bready = 1'b0;
    logic [1:0] bresp;
    logic arvalid = 1'b0;
    logic arready;
    logic [ADDR_W-1:0] araddr = 8'h00;
    logic rvalid;
    logic rready = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic eeprom_present = 1'b0;
    logic otp_configured = 1'b0;
    logic [NUM_FIELDS-1:0][7:0] eeprom_image = {8'h09, 8'h00, 8'h12, 8'h05, 8'h00, 8'h12, 8'h2A};
    logic [NUM_FIELDS-1:0][7:0] otp_image = {8'h0B, 8'h12, 8'h00, 8'h07, 8'h12, 8'h12, 8'h3C};
    logic usb_bus_reset = 1'b0;
    logic lite_reset = 1'b0;
    logic attrs_active;
    logic [7:0] object_store_block_len, superspeed_poll_interval, superspeed_device_len;
    logic [7:0] superspeed_config_len, highspeed_poll_interval, highspeed_device_len, highspeed_config_len;
    logic [55:0] outs;
    int err_total = 0;
    int check_count = 0;

    assign outs = {object_store_block_len, superspeed_poll_interval, superspeed_device_len,
        superspeed_config_len, highspeed_poll_interval, highspeed_device_len, highspeed_config_len};

    always #12.5 mclk = ~mclk;

    usb_descriptor_attribute_regs uut (
        .mclk, .rst_b, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
        .rdata, .rresp, .eeprom_present, .otp_configured, .eeprom_image, .otp_image,
        .usb_bus_reset, .lite_reset, .attrs_active, .object_store_block_len,
        .superspeed_poll_interval, .superspeed_device_len, .superspeed_config_len,
        .highspeed_poll_interval, .highspeed_device_len, .highspeed_config_len
    );

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    // handshakes sampled at the falling edge, released after the rising one
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        logic ta;
        logic tw;
        logic got_b;
        logic [1:0] resp;
        int n;
        n = 0;
        @(posedge mclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        do begin
            @(negedge mclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            got_b = bvalid;
            resp = bresp;
            @(posedge mclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end while (!got_b && n < 100);
        bready <= 1'b0;
        if (!got_b) err_total++;
        `CHK($sformatf("bresp@%h", a), er, resp)
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta;
        logic got_r;
        logic [31:0] d;
        logic [1:0] resp;
        int n;
        n = 0;
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(negedge mclk);
            ta = arvalid && arready;
            got_r = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge mclk);
            if (ta) arvalid <= 1'b0;
            n++;
        end while (!got_r && n < 100);
        rready <= 1'b0;
        if (!got_r) err_total++;
        `CHK($sformatf("rdata@%h", a), ed, d)
        `CHK($sformatf("rresp@%h", a), er, resp)
    endtask : axi_read

    task automatic chk_regs(input logic [31:0] e0, input logic [31:0] e1, input logic [31:0] e2);
        axi_read(OFS_OBJECT_STORE, e0, RESP_OKAY);
        axi_read(OFS_SUPERSPEED, e1, RESP_OKAY);
        axi_read(OFS_HIGHSPEED, e2, RESP_OKAY);
    endtask : chk_regs

    // outputs lag a register change by up to two edges (emul_en to active to outs), so let a few pass
    task automatic chk_out(input logic act, input logic [55:0] e);
        repeat (3) @(negedge mclk);
        `CHK("attrs_active", act, attrs_active)
        `CHK("attr_outputs", e, outs)
    endtask : chk_out

    task automatic restore_pulse(input logic lite);
        @(posedge mclk);
        lite_reset <= lite;
        usb_bus_reset <= !lite;
        @(posedge mclk);
        lite_reset <= 1'b0;
        usb_bus_reset <= 1'b0;
    endtask : restore_pulse

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        chk_regs(32'h00000000, 32'h00060000, 32'h00040000);
        chk_out(1'b0, 56'h0);
        axi_write(OFS_EMUL_CTRL, 32'h00000001, 4'hF, RESP_OKAY);
        axi_read(OFS_EMUL_CTRL, 32'h00000009, RESP_OKAY);
        chk_out(1'b1, 56'h00_06_00_00_04_00_00);
        axi_write(OFS_OBJECT_STORE, 32'hFFFFFFAB, 4'hF, RESP_OKAY);
        axi_read(OFS_OBJECT_STORE, 32'h000000AB, RESP_OKAY);
        axi_write(OFS_SUPERSPEED, 32'hFF0A0705, 4'hF, RESP_OKAY);
        axi_read(OFS_SUPERSPEED, 32'h000A0705, RESP_OKAY);
        axi_write(OFS_HIGHSPEED, 32'hFF081200, 4'hF, RESP_OKAY);
        axi_write(OFS_HIGHSPEED, 32'hFFFFFF12, 4'h1, RESP_OKAY);
        axi_read(OFS_HIGHSPEED, 32'h00081212, RESP_OKAY);
        chk_out(1'b1, 56'hAB_0A_12_12_08_12_12);
        // unmapped place: error answer, nothing stored
        axi_write(8'h40, 32'h000000FF, 4'hF, RESP_SLVERR);
        axi_read(8'h40, 32'h00000000, RESP_SLVERR);
        restore_pulse(1'b1);
        chk_regs(32'h00000000, 32'h00060000, 32'h00040000);
        chk_out(1'b1, 56'h00_06_00_00_04_00_00);
        axi_write(OFS_SUPERSPEED, 32'h00111212, 4'hF, RESP_OKAY);
        // no writes from here on: sources present
        @(posedge mclk);
        otp_configured <= 1'b1;
        restore_pulse(1'b0);
        chk_regs(32'h0000003C, 32'h00071212, 32'h000B1200);
        axi_read(OFS_EMUL_CTRL, 32'h00000005, RESP_OKAY);
        chk_out(1'b0, 56'h0);
        @(posedge mclk);
        eeprom_present <= 1'b1;
        restore_pulse(1'b0);
        chk_regs(32'h0000002A, 32'h00050012, 32'h00090012);
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        chk_regs(32'h0000002A, 32'h00050012, 32'h00090012);
        axi_read(OFS_EMUL_CTRL, 32'h00000006, RESP_OKAY);
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        complete_run();
    end
endmodule : tb
